// *** rtl/program_sequencer_pipeline.sv ***
// Instruction sequencer: phases, fetch/execute pipeline, PC, stack, ALU
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"

module program_sequencer_pipeline #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rstn,
    // Program memory
    output logic         [`PC_MSB:0]    o_pm_addr,
    input  wire seq_pkg::instr_t        i_pm_data,
    // Interrupt requests, already enabled and flagged
    input  wire logic    [`INT_W:0]     i_int_req,
    output logic         [`INT_W:0]     o_int_ack,
    // Oscillator option strap and freed pin
    input  wire logic                   i_rc_osc_sel,
    output logic                        o_second_oscillator_pin,
    // Phase and pipeline view
    output logic         [3:0]          o_instruction_phases,
    output logic                        o_fetch_phase,
    output logic                        o_dummy_cycle,
    // Software-visible state
    output seq_pkg::byte_t              o_program_counter_low_byte,
    output seq_pkg::byte_t              o_acc,
    output seq_pkg::byte_t              o_status
);
    import seq_pkg::*;

    // Decode of an instruction word, used for execute and skip paths
    function automatic kind_t decode(input instr_t w);
        case (w[`OP_MSB:`OP_LSB])
            `OP_ALU:       decode = K_ALU;
            `OP_BRANCH:    decode = K_BRANCH;
            `OP_CALL:      decode = K_CALL;
            `OP_SUB_RET:   decode = K_RET;
            `OP_INT_RET:   decode = K_RET;
            `OP_PCL_LOAD:  decode = K_PCL;
            `OP_SKIP_ZERO: decode = K_SKIP;
            default:       decode = K_NOP;
        endcase
    endfunction

    // Drop bit 12 on the reduced-memory variant
    function automatic pc_t fit_pc(input pc_t p);
        fit_pc = p;
        if (SMALL_VARIANT) begin
            fit_pc[`PC_MSB] = 1'b0;
        end
    endfunction

    phase_t               ph_q;
    pc_t                  pc_q;
    instr_t               ir_q;
    logic                 ir_vld_q;
    byte_t                acc_q;
    byte_t                status_q;
    pc_t                  stk_q [`STK_DEPTH];
    logic [`STK_IDX_W-1:0] sp_q;
    logic                 full_q;
    logic [`INT_W:0]      ack_q;
    logic                 second_oscillator_pin_q;
    logic                 rc_meta_q;
    logic                 rc_sync_q;

    logic                 boundary;
    kind_t                kind;
    logic                 skip_hit;
    logic                 flow_change;
    logic                 int_take;
    logic [`INT_W:0]      int_pick;
    pc_t                  int_vec;
    pc_t                  stk_top;
    pc_t                  target;
    logic [8:0]           alu_res;

    // Phase counter free-runs; its last phase closes the instruction cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ph_q <= PH_FETCH;
        end else begin
            case (ph_q)
                PH_FETCH:  ph_q <= PH_DECODE;
                PH_DECODE: ph_q <= PH_EXEC;
                PH_EXEC:   ph_q <= PH_WRITE;
                PH_WRITE:  ph_q <= PH_FETCH;
                default:   ph_q <= PH_FETCH;
            endcase
        end
    end

    assign boundary = (ph_q == PH_WRITE);

    // Instruction classification of the word now executing
    assign kind     = ir_vld_q ? decode(ir_q) : K_NOP;
    assign skip_hit = (kind == K_SKIP) && (acc_q == 8'h00);
    assign flow_change = (kind == K_BRANCH) || (kind == K_CALL) ||
                         (kind == K_RET) || (kind == K_PCL) || skip_hit;
    assign stk_top  = stk_q[sp_q - 3'h1];
    assign target   = fit_pc(ir_q[`TGT_MSB:0]);

    // Lowest source number wins; the external line is first
    always_comb begin
        int_pick = '0;
        int_vec  = `VEC_RESET;
        for (int i = `INT_W; i >= 0; i--) begin
            if (i_int_req[i]) begin
                int_pick = '0;
                int_pick[i] = 1'b1;
                int_vec = 13'(`VEC_EXT_INT + 13'(i * 4));
            end
        end
    end

    // Only on a real boundary, not during a dummy, and with stack room
    assign int_take = boundary && ir_vld_q && !flow_change &&
                      (|i_int_req) && !full_q;

    // Program counter: increment at fetch, or reload on flow change
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            pc_q <= `PC_RESET;
        end else if (boundary) begin
            if (int_take) begin
                pc_q <= int_vec;
            end else begin
                case (kind)
                    K_BRANCH, K_CALL: pc_q <= target;
                    K_RET:            pc_q <= stk_top;
                    K_PCL:            pc_q <= fit_pc({pc_q[`PC_MSB:`PAGE_LSB],
                                        ir_q[`IMM_MSB:0]});
                    default:          pc_q <= fit_pc(pc_q + 13'h1);
                endcase
            end
        end
    end

    // Fetch register; a flushed word leaves a dummy cycle behind
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ir_q     <= `INSTR_RESET;
            ir_vld_q <= 1'b0;
        end else if (boundary) begin
            ir_q     <= i_pm_data;
            ir_vld_q <= !(flow_change || int_take);
        end
    end

    // Return stack; a full-stack call still pushes and wraps
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            sp_q   <= `STK_IDX_RESET;
            full_q <= 1'b0;
        end else if (boundary) begin
            if (int_take || kind == K_CALL) begin
                sp_q   <= sp_q + 3'h1;
                full_q <= full_q || (sp_q == `STK_IDX_LAST);
            end else if (kind == K_RET) begin
                sp_q   <= sp_q - 3'h1;
                full_q <= 1'b0;
            end
        end
    end

    // Stack storage holds PC values only, no reset needed
    always_ff @(posedge i_sys_clk) begin
        if (boundary && (int_take || kind == K_CALL)) begin
            stk_q[sp_q] <= pc_q;
        end
    end

    // Eight-bit unit: result to accumulator, carry and zero to status
    always_comb begin
        case (ir_q[`ALU_MSB:`ALU_LSB])
            `ALU_ADD: alu_res = {1'b0, acc_q} + {1'b0, ir_q[`IMM_MSB:0]};
            `ALU_SUB: alu_res = {1'b0, acc_q} - {1'b0, ir_q[`IMM_MSB:0]};
            `ALU_AND: alu_res = {1'b0, acc_q & ir_q[`IMM_MSB:0]};
            default:  alu_res = {1'b0, acc_q ^ ir_q[`IMM_MSB:0]};
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            acc_q    <= `ACC_RESET;
            status_q <= `STATUS_RESET;
        end else if (boundary && kind == K_ALU) begin
            acc_q <= alu_res[7:0];
            status_q[`ST_ZERO] <= (alu_res[7:0] == 8'h00);
            // Carry means no borrow on subtract; logic ops leave it alone
            if (ir_q[`ALU_MSB:`ALU_LSB] == `ALU_ADD) begin
                status_q[`ST_CARRY] <= alu_res[8];
            end else if (ir_q[`ALU_MSB:`ALU_LSB] == `ALU_SUB) begin
                status_q[`ST_CARRY] <= !alu_res[8];
            end
        end
    end

    // One-cycle acknowledge, registered so it aligns with the vector load
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            ack_q <= '0;
        end else begin
            ack_q <= int_take ? int_pick : '0;
        end
    end

    // Strap is a pin: two flops before anything reads it
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
        end else begin
            rc_meta_q <= i_rc_osc_sel;
            rc_sync_q <= rc_meta_q;
        end
    end

    // High during the fetch phase only: one high, three low
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            second_oscillator_pin_q <= 1'b0;
        end else begin
            second_oscillator_pin_q <= rc_sync_q && (ph_q == PH_WRITE);
        end
    end

    // Phase view decoded straight from the phase register
    assign o_instruction_phases = 4'h1 << ph_q;
    assign o_fetch_phase        = (ph_q == PH_FETCH);
    assign o_dummy_cycle        = !ir_vld_q;
    assign o_pm_addr            = pc_q;
    assign o_int_ack            = ack_q;
    assign o_second_oscillator_pin = second_oscillator_pin_q;
    // Upper PC bits and the stack index stay hidden
    assign o_program_counter_low_byte = pc_q[`IMM_MSB:0];
    assign o_acc                = acc_q;
    assign o_status             = status_q;

endmodule

`default_nettype wire

// *** rtl/seq_map.svh ***
// Offsets, field positions, encodings and reset values of the sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Program counter and stack geometry
`define PC_W          13
`define PC_MSB        12
`define PC_RESET      13'h0000
`define STK_DEPTH     8
`define STK_IDX_W     3
`define STK_IDX_LAST  3'h7
`define STK_IDX_RESET 3'h0

// Fixed vectors
`define VEC_RESET     13'h0000
`define VEC_EXT_INT   13'h0004
`define VEC_TIMER0    13'h0008
`define VEC_TIMER1    13'h000c
`define VEC_TIMER2    13'h0010
`define VEC_TIMER3    13'h0014
`define INT_SRCS      6
`define INT_W         5

// Instruction word fields
`define OP_MSB        15
`define OP_LSB        13
`define ALU_MSB       12
`define ALU_LSB       11
`define IMM_MSB       7
`define TGT_MSB       12
`define PAGE_LSB      8

// Opcodes
`define OP_ALU        3'h0
`define OP_BRANCH     3'h1
`define OP_CALL       3'h2
`define OP_SUB_RET    3'h3
`define OP_INT_RET    3'h4
`define OP_PCL_LOAD   3'h5
`define OP_SKIP_ZERO  3'h6
`define OP_NOP        3'h7

// Operations of the 8-bit unit
`define ALU_ADD       2'h0
`define ALU_SUB       2'h1
`define ALU_AND       2'h2
`define ALU_XOR       2'h3

// Status register layout and reset values
`define ST_CARRY      0
`define ST_ZERO       1
`define STATUS_RESET  8'h00
`define ACC_RESET     8'h00
`define INSTR_RESET   16'he000

`endif

// *** rtl/seq_pkg.sv ***
// Types shared by the program sequencer
package seq_pkg;

    // Four internal phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_FETCH,
        PH_DECODE,
        PH_EXEC,
        PH_WRITE
    } phase_t;

    // Instruction classes after decode
    typedef enum logic [2:0] {
        K_ALU,
        K_BRANCH,
        K_CALL,
        K_RET,
        K_PCL,
        K_SKIP,
        K_NOP
    } kind_t;

    typedef logic [12:0] pc_t;
    typedef logic [15:0] instr_t;
    typedef logic [7:0]  byte_t;

endpackage

// *** tb/program_memory_model.sv ***
// Program memory model that feeds instruction words to the sequencer
`timescale 1ns/1ps
`default_nettype none
module program_memory_model (
    // Fetch address and word
    input  wire logic [12:0]     i_addr,
    output seq_pkg::instr_t      o_data
);
    seq_pkg::instr_t rom [8192];
    // Unwritten words read as no-operation, so a stray fetch runs on
    initial begin
        foreach (rom[i]) begin
            rom[i] = 16'he000;
        end
    end
    assign o_data = rom[i_addr];
endmodule
`default_nettype wire

// *** tb/program_sequencer_pipeline_asserts.sv ***
// Port-level checks of the program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module seq_checker (
    // Watched ports
    input wire logic              i_sys_clk,
    input wire logic              i_rstn,
    input wire logic [`PC_MSB:0]  o_pm_addr,
    input wire logic [`INT_W:0]   i_int_req,
    input wire logic [`INT_W:0]   o_int_ack,
    input wire logic              o_second_oscillator_pin,
    input wire logic [3:0]        o_instruction_phases,
    input wire logic              o_fetch_phase,
    input wire logic              o_dummy_cycle
);
    import seq_pkg::*;
    logic [12:0] vec_q;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // Vector of the acknowledged source, held for the landing check
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i <= `INT_W; i++) begin
            if (o_int_ack[i]) begin
                vec_q <= 13'(4 + 4 * i);
            end
        end
    end
    chk_phase_onehot: assert property ($onehot(o_instruction_phases))
        else $error("phase vector not one-hot");
    chk_phase_order: assert property (o_instruction_phases[0] |=>
        o_instruction_phases[1] ##1 o_instruction_phases[2]
        ##1 o_instruction_phases[3] ##1 o_instruction_phases[0])
        else $error("phases out of order");
    chk_fetch_flag: assert property (
        o_fetch_phase == o_instruction_phases[0])
        else $error("fetch flag off its phase");
    chk_pc_moves: assert property (
        $changed(o_pm_addr) |-> o_fetch_phase)
        else $error("fetch address moved outside fetch phase");
    chk_osc_fetch: assert property (
        o_second_oscillator_pin |-> o_fetch_phase)
        else $error("oscillator pin high outside fetch phase");
    chk_dummy_whole: assert property (
        o_dummy_cycle && o_fetch_phase |-> o_dummy_cycle [*4])
        else $error("dummy cycle shorter than four phases");
    chk_ack_vector: assert property (
        |o_int_ack |=> ##[0:3] o_pm_addr == vec_q)
        else $error("acknowledge without fetch from its vector");
    chk_ack_granted: assert property (|o_int_ack |-> $onehot(o_int_ack)
        && (o_int_ack & i_int_req) == o_int_ack)
        else $error("acknowledge without a pending request");
endmodule
bind program_sequencer_pipeline seq_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .o_pm_addr(o_pm_addr),
    .i_int_req(i_int_req), .o_int_ack(o_int_ack),
    .o_second_oscillator_pin(o_second_oscillator_pin),
    .o_instruction_phases(o_instruction_phases),
    .o_fetch_phase(o_fetch_phase), .o_dummy_cycle(o_dummy_cycle));
`default_nettype wire

// *** tb/tb_program_sequencer_pipeline.sv ***
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module tb_program_sequencer_pipeline;
    import seq_pkg::*;
    typedef struct { instr_t w; byte_t a; byte_t s; byte_t m; } row_t;
    logic        clk = 1'b0;
    logic        rstn, rc, osc, fet, dum;
    logic [12:0] pc;
    logic [5:0]  req, ack;
    logic [3:0]  ph;
    instr_t      wd;
    byte_t       program_counter_low_byte, acc, st;
    int          fail_count = 0, num_checks = 0, dcnt = 0, nack = 0;
    logic [12:0] trace [$];
    logic [12:0] exp_tr [18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 'h123, 'h124,
        'h140, 'h141, 'ha00, 'ha01, 'h141, 'h142, 'h143};
    // ALU word, accumulator, status and status bits that are defined
    row_t rows [7] = '{'{16'h00ff, 8'hff, 8'h00, 8'h03},
        '{16'h0001, 8'h00, 8'h03, 8'h03}, '{16'h185a, 8'h5a, 8'h00, 8'h02},
        '{16'h1000, 8'h00, 8'h02, 8'h02}, '{16'h0800, 8'h00, 8'h02, 8'h02},
        '{16'h1880, 8'h80, 8'h00, 8'h02}, '{16'h0880, 8'h00, 8'h02, 8'h02}};
    program_memory_model mem (.i_addr(pc), .o_data(wd));
    program_sequencer_pipeline DUT (.i_sys_clk(clk), .i_rstn(rstn),
        .o_pm_addr(pc), .i_pm_data(wd), .i_int_req(req), .o_int_ack(ack),
        .i_rc_osc_sel(rc), .o_second_oscillator_pin(osc),
        .o_instruction_phases(ph), .o_fetch_phase(fet), .o_dummy_cycle(dum),
        .o_program_counter_low_byte(program_counter_low_byte), .o_acc(acc), .o_status(st));
    always #5 clk = ~clk;
    // Fetch trace, dummy cycles and acknowledges, seen mid-cycle
    always @(negedge clk) begin
        if (rstn && (trace.size() == 0 || trace[$] !== pc)) begin
            trace.push_back(pc);
        end
        if (rstn && fet && dum) dcnt++;
        if (rstn && |ack) nack++;
    end
    task automatic cmp(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wait_pc(input logic [12:0] a);
        for (int n = 0; n < 600 && pc !== a; n++) @(negedge clk);
        cmp("fetch address", {3'h0, a}, {3'h0, pc});
    endtask
    // Hold the request one edge past its acknowledge, then drop it
    task automatic take_irq(input int b, output int got);
        got = 0;
        for (int n = 0; n < 60 && got == 0; n++) begin
            @(posedge clk);
            #1;
            if (ack[b] === 1'b1) got = 1;
        end
        @(posedge clk);
        #1 req[b] = 1'b0;
    endtask
    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        final_report;
    end
    initial begin
        int j, k;
        rstn = 1'b0;
        req = 6'h00;
        rc = 1'b0;
        #1;
        foreach (rows[r]) mem.rom[r] = rows[r].w;
        mem.rom[7] = {`OP_BRANCH, 13'h0123};
        mem.rom['h123] = {`OP_PCL_LOAD, 13'h0040};
        mem.rom['h140] = {`OP_CALL, 13'h0a00};
        mem.rom['ha00] = {`OP_SUB_RET, 13'h0000};
        mem.rom['h141] = {`OP_SKIP_ZERO, 13'h0000};
        mem.rom['h142] = {`OP_ALU, 13'h00ff};
        mem.rom['h14] = {`OP_INT_RET, 13'h0000};
        mem.rom['h150] = {`OP_BRANCH, 13'h0200};
        mem.rom['h290] = {`OP_SUB_RET, 13'h0000};
        // Eight nested calls leave every stack level in use at 280
        for (int c = 0; c < 8; c++) begin
            mem.rom['h200 + 16 * c] = {`OP_CALL, 13'('h210 + 16 * c)};
            mem.rom['h201 + 16 * c] = {`OP_SUB_RET, 13'h0000};
        end
        // Plain word after the last return, so a deferred request finds a boundary
        mem.rom['h271] = {`OP_NOP, 13'h0000};
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        foreach (rows[r]) begin
            repeat (r == 0 ? 8 : 4) @(posedge clk);
            #1;
            cmp("acc", {8'h0, rows[r].a}, {8'h0, acc});
            cmp("status", {8'h0, rows[r].s}, {8'h0, st & rows[r].m});
        end
        wait_pc(13'h144);
        cmp("pc low byte", 16'h0044, {8'h0, program_counter_low_byte});
        cmp("dummy cycles", 16'd6, 16'(dcnt));
        cmp("acc after skip", 16'h0, {8'h0, acc});
        foreach (exp_tr[i]) begin
            cmp("trace", 16'(exp_tr[i]), 16'(trace[i]));
        end
        @(posedge clk);
        #1 req[4] = 1'b1;
        take_irq(4, k);
        cmp("timer ack", 16'd1, 16'(k));
        wait_pc(13'h150);
        j = 1;
        foreach (trace[i]) if (trace[i] === 13'h014) j = i;
        cmp("return", {3'h0, trace[j - 1]}, {3'h0, trace[j + 2]});
        wait_pc(13'h282);
        k = nack;
        @(posedge clk);
        #1 req[0] = 1'b1;
        wait_pc(13'h290);
        cmp("ack with full stack", 16'd0, 16'(nack - k));
        take_irq(0, k);
        cmp("ack after return", 16'd1, 16'(k));
        wait_pc(13'h004);
        // Vector runs into the page jump and the call with a full stack
        wait_pc(13'h0a00);
        // Pin stays low without the strap, then pulses once per cycle
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            #1 rc = 1'(m);
            repeat (8) @(posedge clk);
            j = 0;
            repeat (40) begin
                @(negedge clk);
                j += int'(osc);
            end
            cmp("oscillator highs", 16'(10 * m), 16'(j));
        end
        // Reset while every level is in use; a request must land after it
        wait_pc(13'h282);
        @(posedge clk);
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp("pc after reset", 16'h0, {3'h0, pc});
        cmp("acc status after reset", 16'h0, {acc, st});
        cmp("ack dummy after reset", 16'h1, {9'h0, ack, dum});
        cmp("phases after reset", 16'h1, {12'h0, ph});
        rstn = 1'b1;
        req[1] = 1'b1;
        take_irq(1, k);
        cmp("ack after reset", 16'd1, 16'(k));
        wait_pc(13'h008);
        final_report;
    end
endmodule
`default_nettype wire
